// file: fie_front_end.sv
// Instruction fetch, refill buffer, branch history and in-order issue front end
// Functional notes
// - decode four, issue those with free resources
// - issue strictly in program order
// - finish whole aligned group before next group
// - branch into group issues target to end
// - four 32-byte refill entries checked on miss
// - refill hit writes cache and buffer together
// - on true miss fetch then prefetch, one/cycle
// - fill data kept until overwritten by new miss
// - prefetch starts only on a true miss
// - at most one group written per cycle
// - miss enters fill mode, buffer checked each cycle
// - cache rechecked while fill data outstanding
// - cache hit in fill mode stops requests
// - new program counter returns to access mode
// - four valid bits per 64-byte cache block
// - one cycle target calc, access cycle after
// - 2048 two-bit entries indexed by bits 13:3
// - counter saturates, up taken, down not taken
// - upper two values predict taken
// - history never cleared by cache fill
module fie_front_end
	import fie_pkg::*;
(
	input  wire logic              clk,              // Core clock
	input  wire logic              rst,              // Asynchronous reset, active high
	input  wire logic              redirect_valid,   // Load a new program counter
	input  wire logic [VA_W-1:0]   redirect_pc,      // New program counter
	input  wire logic [SLOTS-1:0]  res_free,         // Resources free for each slot
	output logic      [SLOTS-1:0]  slot_valid,       // Slots still waiting in the issue group
	output logic      [GRP_W-1:0]  slot_instr,       // Instructions of the issue group
	output logic      [VA_W-1:0]   slot_pc,          // Address of the issue group
	output logic      [SLOTS-1:0]  issue_valid,      // Slots issued last cycle
	output logic      [GRP_W-1:0]  issue_instr,      // Instructions issued last cycle
	output logic      [VA_W-1:0]   issue_pc,         // Group address of the issue
	output logic                   mtu_req_valid,    // Request to memory_translation_unit
	output logic      [VA_W-1:0]   mtu_req_addr,     // 32-byte aligned request address
	output logic                   mtu_req_prefetch, // Request is a prefetch, not the fetch
	input  wire logic              mtu_req_ready,    // Request taken
	input  wire logic              fill_valid,       // Fill data returning
	input  wire logic [VA_W-1:0]   fill_addr,        // Address of the returning entry
	input  wire logic [LINE_W-1:0] fill_data,        // 32 bytes of fill data
	input  wire logic              br_res_valid,     // Branch outcome known
	input  wire logic [VA_W-1:0]   br_res_pc,        // Address of the resolved branch
	input  wire logic              br_res_taken,     // Branch was taken
	output logic                   fill_mode         // Cache is in fill mode
);

	// Storage arrays
	logic [GRP_W-1:0]        ic_data [IC_SETS][SUBS];
	logic [TAG_W-1:0]        ic_tag  [IC_SETS];
	logic [SUBS-1:0]         ic_ok   [IC_SETS];
	logic [1:0]              bht     [BHT_N];
	logic [LINE_W-1:0]       rb_data [RB_N];
	logic [VA_W-LINE_LO-1:0] rb_addr [RB_N];
	logic [RB_N-1:0]         rb_live;
	logic [RB_N-1:0]         rb_ok;
	logic [2:0]              seq_idx;

	// Fetch state
	fie_mode_t        mode;
	logic [VA_W-1:0]  fetch_pc;
	logic             br_calc;
	logic [VA_W-1:0]  br_pc;
	logic [20:0]      br_disp;

	// Group buffer
	logic [GRP_W-1:0] q_instr [Q_DEPTH];
	logic [SLOTS-1:0] q_mask  [Q_DEPTH];
	logic [VA_W-1:0]  q_pc    [Q_DEPTH];
	logic             q_wp;
	logic             q_rp;
	logic [1:0]       q_cnt;

	// Lookup and issue terms
	logic [7:0]       ic_idx;
	logic [1:0]       ic_sub;
	logic             ic_hit;
	logic             rb_known;
	logic             rb_hit;
	logic [1:0]       rb_sel;
	logic             true_miss;
	logic             fetch_go;
	logic             grp_ok;
	logic [GRP_W-1:0] grp_data;
	logic [SLOTS-1:0] grp_mask;
	logic             br_found;
	logic [VA_W-1:0]  br_found_pc;
	logic [20:0]      br_found_disp;
	logic             seq_start;
	logic             seq_stop;
	logic             q_push;
	logic             q_pop;
	logic [SLOTS-1:0] issue_now;
	logic [VA_W-1:0]  next_tgt;

	// Cache and refill buffer lookup at the fetch address
	always_comb begin
		ic_idx = fetch_pc[BHT_HI:IDX_LO];
		ic_sub = fetch_pc[IDX_LO-1:SUB_LO];
		ic_hit = ic_ok[ic_idx][ic_sub] && (ic_tag[ic_idx] == fetch_pc[VA_W-1:BHT_HI+1]);
		rb_known = 1'b0;
		rb_sel = 2'h0;
		for (int i = 0; i < RB_N; i++) begin
			if (rb_live[i] && rb_addr[i] == fetch_pc[VA_W-1:LINE_LO]) begin
				rb_known = 1'b1;
				rb_sel = 2'(i);
			end
		end
		rb_hit = rb_known && rb_ok[rb_sel];
		true_miss = !ic_hit && !rb_known;
	end

	// Fetch proceeds only when the group buffer has room
	always_comb begin
		fetch_go = !br_calc && !redirect_valid && (q_cnt != Q_FULL);
		grp_ok = fetch_go && (ic_hit || rb_hit);
		if (ic_hit) begin
			grp_data = ic_data[ic_idx][ic_sub];
		end else if (fetch_pc[SUB_LO]) begin
			grp_data = rb_data[rb_sel][LINE_W-1:GRP_W];
		end else begin
			grp_data = rb_data[rb_sel][GRP_W-1:0];
		end
		seq_start = fetch_go && true_miss && !(mtu_req_valid && !mtu_req_ready);
		seq_stop = fetch_go && ic_hit && (mode == FIE_FILL);
		q_push = grp_ok;
	end

	// Branch scan of the fetched group, slots from the entry point onward
	always_comb begin
		logic [INS_W-1:0] ins;
		logic [VA_W-1:0]  spc;
		logic             take;
		ins = '0;
		spc = '0;
		take = 1'b0;
		grp_mask = 4'hf << fetch_pc[3:2];
		br_found = 1'b0;
		br_found_pc = '0;
		br_found_disp = '0;
		for (int i = 0; i < SLOTS; i++) begin
			ins = grp_data[i*INS_W +: INS_W];
			spc = {fetch_pc[VA_W-1:SUB_LO], 2'(i), 2'h0};
			take = (ins[31:26] == BR_ALWAYS) || bht[spc[BHT_HI:BHT_LO]][1];
			if (!br_found && grp_mask[i] && ins[31:30] == BR_CLASS && take) begin
				br_found = 1'b1;
				br_found_pc = spc;
				br_found_disp = ins[20:0];
			end else if (br_found) begin
				grp_mask[i] = 1'b0;
			end
		end
	end

	// Target is the branch address plus four plus the scaled displacement
	assign next_tgt = br_pc + INS_BYTES + {{20{br_disp[20]}}, br_disp, 2'h0};

	// Fetch address, cache mode and branch target cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_pc <= RST_PC;
			mode <= FIE_ACCESS;
			fill_mode <= 1'b0;
			br_calc <= 1'b0;
			br_pc <= '0;
			br_disp <= '0;
		end else if (redirect_valid) begin
			fetch_pc <= redirect_pc;
			mode <= FIE_ACCESS;
			fill_mode <= 1'b0;
			br_calc <= 1'b0;
		end else if (br_calc) begin
			fetch_pc <= next_tgt;
			mode <= FIE_ACCESS;
			fill_mode <= 1'b0;
			br_calc <= 1'b0;
		end else if (fetch_go) begin
			if (ic_hit) begin
				mode <= FIE_ACCESS;
				fill_mode <= 1'b0;
			end else begin
				mode <= FIE_FILL;
				fill_mode <= 1'b1;
			end
			if (grp_ok) begin
				fetch_pc <= {fetch_pc[VA_W-1:SUB_LO] + 39'h1, 4'h0};
				br_calc <= br_found;
				br_pc <= br_found_pc;
				br_disp <= br_found_disp;
			end
		end
	end

	// Cache data and tag write from the refill buffer
	always_ff @(posedge clk) begin
		if (fetch_go && !ic_hit && rb_hit) begin
			ic_data[ic_idx][ic_sub] <= grp_data;
			ic_tag[ic_idx] <= fetch_pc[VA_W-1:BHT_HI+1];
		end
	end

	// Subblock valid bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < IC_SETS; i++) begin
				ic_ok[i] <= '0;
			end
		end else if (fetch_go && !ic_hit && rb_hit) begin
			if (ic_tag[ic_idx] == fetch_pc[VA_W-1:BHT_HI+1]) begin
				ic_ok[ic_idx][ic_sub] <= 1'b1;
			end else begin
				ic_ok[ic_idx] <= 4'h1 << ic_sub;
			end
		end
	end

	// Refill buffer entries and request sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rb_live <= '0;
			rb_ok <= '0;
			seq_idx <= SEQ_DONE;
			mtu_req_valid <= 1'b0;
			mtu_req_addr <= '0;
			mtu_req_prefetch <= 1'b0;
			for (int i = 0; i < RB_N; i++) begin
				rb_addr[i] <= '0;
			end
		end else if (seq_start) begin
			for (int i = 0; i < RB_N; i++) begin
				rb_addr[i] <= fetch_pc[VA_W-1:LINE_LO] + 38'(i);
			end
			rb_live <= 4'hf;
			rb_ok <= '0;
			seq_idx <= 3'h1;
			mtu_req_valid <= 1'b1;
			mtu_req_addr <= {fetch_pc[VA_W-1:LINE_LO], 5'h0};
			mtu_req_prefetch <= 1'b0;
		end else begin
			if (seq_stop) begin
				for (int j = 0; j < RB_N; j++) begin
					if (3'(j) >= seq_idx || (3'(j) + 3'h1 == seq_idx && mtu_req_valid && !mtu_req_ready)) begin
						rb_live[j] <= 1'b0;
					end
				end
				seq_idx <= SEQ_DONE;
				mtu_req_valid <= 1'b0;
			end else if (mtu_req_valid && mtu_req_ready) begin
				if (seq_idx == SEQ_DONE) begin
					mtu_req_valid <= 1'b0;
				end else begin
					mtu_req_addr <= mtu_req_addr + LINE_BYTES;
					mtu_req_prefetch <= 1'b1;
					seq_idx <= seq_idx + 3'h1;
				end
			end
			for (int i = 0; i < RB_N; i++) begin
				if (fill_valid && rb_live[i] && !rb_ok[i] && rb_addr[i] == fill_addr[VA_W-1:LINE_LO]) begin
					rb_ok[i] <= 1'b1;
				end
			end
		end
	end

	// Fill data capture
	always_ff @(posedge clk) begin
		for (int i = 0; i < RB_N; i++) begin
			if (fill_valid && rb_live[i] && !rb_ok[i] && rb_addr[i] == fill_addr[VA_W-1:LINE_LO]) begin
				rb_data[i] <= fill_data;
			end
		end
	end

	// Branch history update, never cleared by fills or reset
	always_ff @(posedge clk) begin
		if (br_res_valid) begin
			if (br_res_taken && bht[br_res_pc[BHT_HI:BHT_LO]] != CTR_MAX) begin
				bht[br_res_pc[BHT_HI:BHT_LO]] <= bht[br_res_pc[BHT_HI:BHT_LO]] + 2'h1;
			end else if (!br_res_taken && bht[br_res_pc[BHT_HI:BHT_LO]] != CTR_MIN) begin
				bht[br_res_pc[BHT_HI:BHT_LO]] <= bht[br_res_pc[BHT_HI:BHT_LO]] - 2'h1;
			end
		end
	end

	// In-order issue: stop at the first slot whose resources are busy
	always_comb begin
		logic blocked;
		blocked = 1'b0;
		for (int i = 0; i < SLOTS; i++) begin
			issue_now[i] = slot_valid[i] && res_free[i] && !blocked;
			if (slot_valid[i] && !res_free[i]) begin
				blocked = 1'b1;
			end
		end
		q_pop = (q_cnt != 2'h0) && ((slot_valid & ~issue_now) == '0);
	end

	// Two-entry group buffer between fetch and issue
	always_ff @(posedge clk) begin
		if (q_push) begin
			q_instr[q_wp] <= grp_data;
			q_mask[q_wp] <= grp_mask;
			q_pc[q_wp] <= {fetch_pc[VA_W-1:SUB_LO], 4'h0};
		end
	end

	// Buffer pointers, flushed by a new program counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_wp <= 1'b0;
			q_rp <= 1'b0;
			q_cnt <= 2'h0;
		end else if (redirect_valid) begin
			q_wp <= 1'b0;
			q_rp <= 1'b0;
			q_cnt <= 2'h0;
		end else begin
			q_wp <= q_wp ^ q_push;
			q_rp <= q_rp ^ q_pop;
			q_cnt <= q_cnt + {1'b0, q_push} - {1'b0, q_pop};
		end
	end

	// Issue group and issued slots
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_valid <= '0;
			slot_instr <= '0;
			slot_pc <= '0;
			issue_valid <= '0;
			issue_instr <= '0;
			issue_pc <= '0;
		end else begin
			issue_valid <= issue_now;
			issue_instr <= slot_instr;
			issue_pc <= slot_pc;
			if (redirect_valid) begin
				slot_valid <= '0;
			end else if (q_pop) begin
				slot_valid <= q_mask[q_rp];
				slot_instr <= q_instr[q_rp];
				slot_pc <= q_pc[q_rp];
			end else begin
				slot_valid <= slot_valid & ~issue_now;
			end
		end
	end

endmodule

// file: fie_front_end_monitor.sv
// Checker of the front end port behaviour, bound to the design
module fie_front_end_checker
	import fie_pkg::*;
(
	input wire logic              clk,              // Core clock
	input wire logic              rst,              // Reset
	input wire logic              redirect_valid,   // New program counter
	input wire logic [SLOTS-1:0]  res_free,         // Free resources
	input wire logic [SLOTS-1:0]  slot_valid,       // Waiting slots
	input wire logic [GRP_W-1:0]  slot_instr,       // Group words
	input wire logic [VA_W-1:0]   slot_pc,          // Group address
	input wire logic [SLOTS-1:0]  issue_valid,      // Issued slots
	input wire logic [GRP_W-1:0]  issue_instr,      // Issued words
	input wire logic [VA_W-1:0]   issue_pc,         // Issued address
	input wire logic              mtu_req_valid,    // Request shown
	input wire logic [VA_W-1:0]   mtu_req_addr,     // Request address
	input wire logic              mtu_req_prefetch, // Prefetch flag
	input wire logic              mtu_req_ready,    // Request taken
	input wire logic              fill_mode         // Fill mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [SLOTS-1:0] iss_mask; // Slots allowed to issue
	logic             blk;      // This or an earlier slot is stuck
	logic             take;     // Request accepted
	logic [2:0]       seq_cnt;  // Requests taken in the sequence
	// In-order issue mask
	always_comb begin
		blk = 1'b0;
		iss_mask = '0;
		for (int i = 0; i < SLOTS; i++) begin
			if (slot_valid[i] && !res_free[i]) blk = 1'b1;
			iss_mask[i] = slot_valid[i] && !blk;
		end
	end
	// Count of requests in the current sequence
	assign take = mtu_req_valid && mtu_req_ready;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) seq_cnt <= 3'h0;
		else if (take) seq_cnt <= mtu_req_prefetch ? seq_cnt + 3'h1 : 3'h1;
	end
	property p_issue_mask; !redirect_valid |=> issue_valid == $past(iss_mask); endproperty
	a_issue_mask: assert property (p_issue_mask) else $error("issue mask wrong");
	property p_issue_data; issue_valid != '0 |-> issue_pc == $past(slot_pc) && issue_instr == $past(slot_instr);
	endproperty
	a_issue_data: assert property (p_issue_data) else $error("issue data wrong");
	property p_group_hold;
		slot_valid != '0 && iss_mask != slot_valid && !redirect_valid
		|=> slot_valid == $past(slot_valid & ~iss_mask) && $stable(slot_pc);
	endproperty
	a_group_hold: assert property (p_group_hold) else $error("group left early");
	property p_req_hold;
		mtu_req_valid && !mtu_req_ready |=> !mtu_req_valid || ($stable(mtu_req_addr) && $stable(mtu_req_prefetch));
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request changed");
	property p_req_next;
		take && (!mtu_req_prefetch || seq_cnt < 3'h3) |=> !fill_mode || (mtu_req_valid &&
		(!mtu_req_prefetch || mtu_req_addr == $past(mtu_req_addr) + LINE_BYTES));
	endproperty
	a_req_next: assert property (p_req_next) else $error("prefetch missing");
	property p_seq_len; take && mtu_req_prefetch |-> seq_cnt inside {3'h1, 3'h2, 3'h3}; endproperty
	a_seq_len: assert property (p_seq_len) else $error("too many prefetches");
	property p_start_fetch; $rose(mtu_req_valid) |-> !mtu_req_prefetch && fill_mode; endproperty
	a_start_fetch: assert property (p_start_fetch) else $error("sequence start wrong");
	property p_align; mtu_req_valid |-> mtu_req_addr[4:0] == 5'h00; endproperty
	a_align: assert property (p_align) else $error("request unaligned");
	property p_redirect; redirect_valid |=> !fill_mode; endproperty
	a_redirect: assert property (p_redirect) else $error("fill mode kept");
	property p_reset; $fell(rst) |-> !fill_mode && !mtu_req_valid && slot_valid == '0; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	c_prefetch: cover property (take && mtu_req_prefetch);
	c_full_issue: cover property (issue_valid == 4'hf);
	c_redirect: cover property (redirect_valid ##1 fill_mode == 1'b0);
	c_stop: cover property (fill_mode && mtu_req_valid ##1 !fill_mode && !mtu_req_valid);
endmodule
bind fie_front_end fie_front_end_checker u_chk (.clk, .rst, .redirect_valid, .res_free, .slot_valid,
	.slot_instr, .slot_pc, .issue_valid, .issue_instr, .issue_pc, .mtu_req_valid, .mtu_req_addr,
	.mtu_req_prefetch, .mtu_req_ready, .fill_mode);

// file: fie_front_end_test.sv
// Self-checking bench of the front end with a fill model
module fie_front_end_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fie_pkg::*;
	logic              clk, rst, redirect_valid, br_res_valid, br_res_taken, guard;
	logic [VA_W-1:0]   redirect_pc, br_res_pc, slot_pc, issue_pc, mtu_req_addr, fill_addr, exp_pc, pc;
	logic [SLOTS-1:0]  res_free, slot_valid, issue_valid;
	logic [GRP_W-1:0]  slot_instr, issue_instr;
	logic              mtu_req_valid, mtu_req_prefetch, mtu_req_ready, fill_valid, fill_mode;
	logic [LINE_W-1:0] fill_data;
	int                errors, compares, issued;
	logic [INS_W-1:0]  word;
	fie_front_end uut (.clk(clk), .rst(rst), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
		.res_free(res_free), .slot_valid(slot_valid), .slot_instr(slot_instr), .slot_pc(slot_pc),
		.issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc),
		.mtu_req_valid(mtu_req_valid), .mtu_req_addr(mtu_req_addr), .mtu_req_prefetch(mtu_req_prefetch),
		.mtu_req_ready(mtu_req_ready), .fill_valid(fill_valid), .fill_addr(fill_addr), .fill_data(fill_data),
		.br_res_valid(br_res_valid), .br_res_pc(br_res_pc), .br_res_taken(br_res_taken), .fill_mode(fill_mode));
	fie_mtu_model u_mtu (.clk(clk), .rst(rst), .req_valid(mtu_req_valid), .req_addr(mtu_req_addr),
		.req_ready(mtu_req_ready), .fill_valid(fill_valid), .fill_addr(fill_addr), .fill_data(fill_data));
	// Clock generation
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string name, input logic [VA_W-1:0] exp, input logic [VA_W-1:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Issue until n more words issued, random resources and history updates
	task automatic run(input int n);
		int target;
		target = issued + n;
		for (int t = 0; t < 4000 && issued < target; t++) begin
			@(negedge clk);
			res_free = 4'($urandom);
			br_res_valid = 1'($urandom);
			br_res_taken = 1'($urandom);
			br_res_pc = VA_W'($urandom);
		end
		if (issued < target) begin
			errors++;
			$display("[FAIL] issue_count expected %0d seen %0d", target, issued);
			test_done;
		end
	endtask
	// Quiet issue, then load a new program counter
	task automatic redir(input logic [VA_W-1:0] a);
		@(negedge clk);
		res_free = 4'h0;
		repeat (4) @(negedge clk);
		redirect_pc = a;
		redirect_valid = 1'b1;
		@(negedge clk);
		redirect_valid = 1'b0;
		exp_pc = a;
	endtask
	// Reference model: sequential program order, word value follows address
	always @(negedge clk) begin
		if (!rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				if (issue_valid[i] === 1'b1) begin
					pc = issue_pc + (VA_W'(i) << 2);
					word = u_mtu.word_at(pc);
					check("issue_pc", exp_pc, pc);
					check("issue_instr", VA_W'(word), VA_W'(issue_instr[i*INS_W +: INS_W]));
					// Taken jump: the target follows, the rest of its group is skipped
					if (word[31:26] == BR_ALWAYS) begin
						exp_pc = exp_pc + INS_BYTES + {{20{word[20]}}, word[20:0], 2'h0};
					end else begin
						exp_pc = exp_pc + INS_BYTES;
					end
					issued++;
				end
			end
			if (guard) check("req_on_hit", '0, VA_W'(mtu_req_valid && mtu_req_addr < 43'h100));
		end
	end
	// Main sequence
	initial begin
		errors = 0;
		compares = 0;
		issued = 0;
		guard = 1'b0;
		rst = 1'b1;
		redirect_valid = 1'b0;
		redirect_pc = '0;
		res_free = 4'h0;
		br_res_valid = 1'b0;
		br_res_taken = 1'b0;
		br_res_pc = '0;
		exp_pc = RST_PC;
		void'($urandom(86));
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("reset_state", '0, VA_W'({fill_mode, mtu_req_valid, slot_valid, issue_valid}));
		run(128);
		redir(43'h000_0000_1008);
		run(30);
		redir(43'h000_0000_2000);
		run(48);
		redir(RST_PC);
		guard = 1'b1;
		run(64);
		guard = 1'b0;
		res_free = 4'h0;
		repeat (40) @(negedge clk);
		run(40);
		redir(43'h000_0000_2020);
		run(24);
		test_done;
	end
endmodule

// file: fie_mtu_model.sv
// Behavioural translation unit returning 32-byte fills in order
module fie_mtu_model
	import fie_pkg::*;
(
	input  wire logic              clk,        // Core clock
	input  wire logic              rst,        // Reset
	input  wire logic              req_valid,  // Request shown
	input  wire logic [VA_W-1:0]   req_addr,   // Request address
	output logic                   req_ready,  // Request taken
	output logic                   fill_valid, // Fill pulse
	output logic      [VA_W-1:0]   fill_addr,  // Fill address
	output logic      [LINE_W-1:0] fill_data   // Fill data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [VA_W-1:0] pend[$];
	int              wait_cnt;
	// Data pattern: word value follows its address, with jumps placed in one region
	function automatic logic [INS_W-1:0] word_at(input logic [VA_W-1:0] a);
		if (a[15:12] == 4'h2 && a[5:2] == 4'h5) return {BR_ALWAYS, 5'h00, 21'h000007};
		return {2'h0, a[31:2]};
	endfunction
	// Random ready, fills after a random delay, idle lines toggle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			req_ready <= 1'b0;
			fill_valid <= 1'b0;
			fill_addr <= '0;
			fill_data <= '0;
			wait_cnt <= 0;
			pend.delete();
		end else begin
			if (req_valid && req_ready) pend.push_back(req_addr);
			req_ready <= ($urandom_range(3) != 0);
			if (wait_cnt > 0 || pend.size() == 0) begin
				fill_valid <= 1'b0;
				fill_addr <= ~fill_addr;
				fill_data <= ~fill_data;
				if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
			end else begin
				fill_valid <= 1'b1;
				fill_addr <= pend[0];
				for (int k = 0; k < 8; k++) fill_data[k*INS_W +: INS_W] <= word_at(pend[0] + (VA_W'(k) << 2));
				void'(pend.pop_front());
				wait_cnt <= $urandom_range(5);
			end
		end
	end
endmodule

// file: fie_pkg.sv
// Shared constants and types of the instruction fetch and issue front end
package fie_pkg;
	localparam int VA_W    = 43;   // Virtual address width
	localparam int INS_W   = 32;   // One instruction
	localparam int SLOTS   = 4;    // Instructions per aligned fetch group
	localparam int GRP_W   = 128;  // Aligned 16-byte fetch group
	localparam int LINE_W  = 256;  // One 32-byte refill buffer entry
	localparam int RB_N    = 4;    // Refill buffer entries
	localparam int IC_SETS = 256;  // 16 KB of 64-byte blocks
	localparam int SUBS    = 4;    // 16-byte subblocks per block
	localparam int TAG_W   = 29;   // Address bits 42:14
	localparam int BHT_N   = 2048; // Branch history entries
	localparam int BHT_LO  = 3;    // Lowest history index bit
	localparam int BHT_HI  = 13;   // Highest history index bit
	localparam int IDX_LO  = 6;    // Lowest cache index bit
	localparam int SUB_LO  = 4;    // Lowest subblock select bit
	localparam int LINE_LO = 5;    // Lowest refill entry address bit
	localparam int Q_DEPTH = 2;    // Entries of the group buffer

	localparam logic [VA_W-1:0] RST_PC     = 43'h000_0000_0000; // Fetch address after reset
	localparam logic [VA_W-1:0] LINE_BYTES = 43'h000_0000_0020; // Stride of one prefetch
	localparam logic [VA_W-1:0] INS_BYTES  = 43'h000_0000_0004; // Stride of one instruction
	localparam logic [1:0]      BR_CLASS   = 2'h3;             // Opcode top bits of branches
	localparam logic [5:0]      BR_ALWAYS  = 6'h30;            // Unconditional branch opcode
	localparam logic [1:0]      CTR_MAX    = 2'h3;             // Saturating counter top
	localparam logic [1:0]      CTR_MIN    = 2'h0;             // Saturating counter bottom
	localparam logic [2:0]      SEQ_DONE   = 3'h4;             // Request index past the last entry
	localparam logic [1:0]      Q_FULL     = 2'h2;             // Group buffer occupancy when full

	typedef enum logic {FIE_ACCESS, FIE_FILL} fie_mode_t;
endpackage
